// ---- core/trt_timer.sv ----
// Three-channel count-down timer with auto-reload and channel 2 capture.
//
// Operation
// RL1 - Each channel has a 32-bit down counter and a 32-bit reload value.
// RL2 - A channel counts only while its run bit in the start register is one.
// RL3 - Counter underflow sets that channel's underflow flag.
// RL4 - On underflow the reload value is loaded and counting goes on.
// RL5 - Underflow interrupt is underflow flag AND underflow interrupt enable.
// RL6 - Internal rates: peripheral clock divided by 4, 16, 64, 256, 1024.
// RL7 - The external pin may be the count source, on chosen edges.
// RL8 - The real-time-clock output may be the count source.
// RL9 - Channel 2 copies its counter into the capture register on pin edges.
// RL10 - Capture register updates only while the capture flag is clear.
// RL11 - Each capture requests DMA, never while a request is outstanding.
// RL12 - Capture interrupt needs capture flag set and capture control 11.
// RL13 - Four interrupts: ch0, ch1, ch2 underflow, then capture, by priority.
// RL14 - No capture happens in standby.
// RL15 - Software stops a channel before writing its registers.
// RL16 - A counter read coinciding with a decrement returns the old value.
// RL17 - The pin count rate stays at or below a quarter of the clock.
// RL18 - Software resets the RTC divider when selecting the RTC source.
// RL19 - For capture the pin is an input and an internal source counts.
// RL20 - Software configures source, enables, capture, reload, count, run.
// RL21 - Source codes: 0-4 prescales, 6 RTC, 7 pin, 5 reserved.
// RL22 - Edge codes: 00 rising, 01 falling, 1x both; also for capture.
// RL23 - Flags clear on writing zero; writing one leaves them alone.
// RL24 - Capture control: 00 off, 10 DMA only, 11 DMA and interrupt.
// RL25 - The pin is sampled on the clock and edges found between samples.
// RL26 - Channels run independently with their own settings.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module trt_timer
    import trt_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  sys_rst_i,
    // Register port
    input  wire logic [`TRT_ADDR_W-1:0] addr_i,
    input  wire logic [`TRT_DATA_W-1:0] wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [`TRT_DATA_W-1:0] rdata_o,
    // Count sources and power state
    input  wire logic                  rtc_clk_i,
    input  wire logic                  standby_i,
    // Timer clock pin
    input  wire logic                  timer_clock_pin_i,
    output logic                       timer_clock_pin_o,
    output logic                       timer_clock_pin_oe_o,
    // Interrupt requests, bit 0 highest priority
    output logic [3:0]                 irq_o,
    output logic                       irq_any_o,
    output logic [1:0]                 irq_id_o,
    // DMA request from capture
    output logic                       dma_req_o,
    input  wire logic                  dma_ack_i
);

    localparam int NCH = `TRT_NUM_CH;
    localparam int CAP = `TRT_CAP_CH;

    // Channel state.
    trt_word_t cnt_q   [NCH];
    trt_word_t rel_q   [NCH];
    trt_cks_t  cks_q   [NCH];
    trt_edge_t edge_q  [NCH];
    logic      underflow_irq_enable_q  [NCH];
    logic      uf_q    [NCH];
    logic [NCH-1:0] run_q;
    logic      oe_q;

    // Capture state of channel 2.
    logic [1:0] capc_q;
    logic       capf_q;
    trt_word_t  capr_q;

    // Sampled inputs.
    logic pin_q;
    logic pin_prev_q;
    logic rtc_q;
    logic rtc_prev_q;

    logic [`TRT_NUM_PRE-1:0] pre_tick;
    logic [NCH-1:0]          tick;
    logic [NCH-1:0]          unf;
    logic [NCH-1:0]          ctl_wr;
    logic [NCH-1:0]          cnt_wr;
    logic [NCH-1:0]          rel_wr;
    logic                    pin_rise;
    logic                    pin_fall;
    logic                    rtc_rise;
    logic                    cap_evt;
    logic [3:0]              irq_d;
    trt_word_t               rd_val;

    trt_prescaler u_pre (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_o    (pre_tick)
    );

    // Byte address of a register inside channel block ch.
    function automatic trt_addr_t ch_addr(input int ch, input int off);
        return trt_addr_t'(`TRT_CH_BASE + ch * `TRT_CH_STRIDE + off);
    endfunction

    // Whether the chosen edge setting matches the detected edges.
    function automatic logic edge_hit(input trt_edge_t sel,
                                      input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        if (sel[1]) begin
            hit = rise | fall; // RL22
        end else if (sel == `TRT_EDGE_FALL) begin
            hit = fall; // RL22
        end else begin
            hit = rise; // RL22
        end
        return hit;
    endfunction

    // Sample the pin and the RTC output, then compare successive samples.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_q      <= 1'b0;
            pin_prev_q <= 1'b0;
            rtc_q      <= 1'b0;
            rtc_prev_q <= 1'b0;
        end else begin
            pin_q      <= timer_clock_pin_i; // RL25
            pin_prev_q <= pin_q;
            rtc_q      <= rtc_clk_i;
            rtc_prev_q <= rtc_q;
        end
    end

    assign pin_rise = pin_q & ~pin_prev_q; // RL25
    assign pin_fall = ~pin_q & pin_prev_q; // RL25
    assign rtc_rise = rtc_q & ~rtc_prev_q;

    // Per-channel count enable and register write decode.
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ctl_wr[c] = wr_i && (addr_i == ch_addr(c, `TRT_OFF_CTRL));
            cnt_wr[c] = wr_i && (addr_i == ch_addr(c, `TRT_OFF_COUNT));
            rel_wr[c] = wr_i && (addr_i == ch_addr(c, `TRT_OFF_RELOAD));
            case (cks_q[c]) // RL21
                `TRT_CKS_DIV4:    tick[c] = pre_tick[0]; // RL6
                `TRT_CKS_DIV16:   tick[c] = pre_tick[1]; // RL6
                `TRT_CKS_DIV64:   tick[c] = pre_tick[2]; // RL6
                `TRT_CKS_DIV256:  tick[c] = pre_tick[3]; // RL6
                `TRT_CKS_DIV1024: tick[c] = pre_tick[4]; // RL6
                `TRT_CKS_RTC:     tick[c] = rtc_rise; // RL8
                `TRT_CKS_PIN: begin
                    tick[c] = edge_hit(edge_q[c], pin_rise, pin_fall); // RL7
                end
                default:          tick[c] = 1'b0;
            endcase
            // Only the RTC source keeps a channel counting in standby.
            if (standby_i && (cks_q[c] != `TRT_CKS_RTC)) begin
                tick[c] = 1'b0;
            end
            tick[c] = tick[c] & run_q[c]; // RL2 RL26
            unf[c]  = tick[c] && (cnt_q[c] == `TRT_RST_WORD); // RL3
        end
    end

    // Start register and pin control register.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            run_q <= '0;
            oe_q  <= 1'b0;
        end else begin
            if (wr_i && addr_i == `TRT_OFF_START) begin
                run_q <= wdata_i[NCH-1:0]; // RL2
            end
            if (wr_i && addr_i == `TRT_OFF_PINCTL) begin
                oe_q <= wdata_i[`TRT_OE_BIT];
            end
        end
    end

    // Counters and reload values.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int c = 0; c < NCH; c++) begin
                cnt_q[c] <= `TRT_RST_WORD;
                rel_q[c] <= `TRT_RST_WORD;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (rel_wr[c]) begin
                    rel_q[c] <= wdata_i; // RL1
                end
                if (cnt_wr[c]) begin
                    cnt_q[c] <= wdata_i;
                end else if (unf[c]) begin
                    cnt_q[c] <= rel_q[c]; // RL4
                end else if (tick[c]) begin
                    cnt_q[c] <= cnt_q[c] - 32'h0000_0001; // RL1
                end
            end
        end
    end

    // Control fields and underflow flags; a new underflow beats a clear.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int c = 0; c < NCH; c++) begin
                cks_q[c]  <= `TRT_RST_CKS;
                edge_q[c] <= `TRT_RST_EDGE;
                underflow_irq_enable_q[c] <= 1'b0;
                uf_q[c]   <= 1'b0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (ctl_wr[c]) begin
                    cks_q[c]  <= wdata_i[`TRT_CKS_MSB:`TRT_CKS_LSB];
                    edge_q[c] <= wdata_i[`TRT_EDGE_MSB:`TRT_EDGE_LSB];
                    underflow_irq_enable_q[c] <= wdata_i[`TRT_UNDERFLOW_IRQ_ENABLE_BIT];
                end
                if (unf[c]) begin
                    uf_q[c] <= 1'b1; // RL3
                end else if (ctl_wr[c] && !wdata_i[`TRT_UF_BIT]) begin
                    uf_q[c] <= 1'b0; // RL23
                end
            end
        end
    end

    // Capture is armed by control 10 or 11 and is off in standby.
    assign cap_evt = capc_q[1] && !standby_i // RL14 RL24
                     && edge_hit(edge_q[CAP], pin_rise, pin_fall); // RL9

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            capc_q <= `TRT_RST_CAPC;
            capf_q <= 1'b0;
        end else begin
            if (ctl_wr[CAP]) begin
                capc_q <= wdata_i[`TRT_CAPC_MSB:`TRT_CAPC_LSB];
            end
            if (cap_evt) begin
                capf_q <= 1'b1;
            end else if (ctl_wr[CAP] && !wdata_i[`TRT_CAPF_BIT]) begin
                capf_q <= 1'b0; // RL23
            end
        end
    end

    // The capture register keeps its earlier value while the flag is set.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            capr_q <= `TRT_RST_WORD;
        end else if (cap_evt && !capf_q) begin
            capr_q <= cnt_q[CAP]; // RL9 RL10
        end
    end

    // One outstanding DMA request at a time; the acknowledge ends it.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dma_req_o <= 1'b0;
        end else if (dma_req_o) begin
            if (dma_ack_i) begin
                dma_req_o <= 1'b0; // RL11
            end
        end else if (cap_evt) begin
            dma_req_o <= 1'b1; // RL11
        end
    end

    // Interrupt lines and the index of the highest-priority active one.
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            irq_d[c] = uf_q[c] & underflow_irq_enable_q[c]; // RL5
        end
        irq_d[3] = capf_q && (capc_q == `TRT_CAPC_IRQ); // RL12
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_o     <= '0;
            irq_any_o <= 1'b0;
            irq_id_o  <= 2'h0;
        end else begin
            irq_o     <= irq_d;
            irq_any_o <= |irq_d;
            if (irq_d[0]) begin
                irq_id_o <= 2'h0; // RL13
            end else if (irq_d[1]) begin
                irq_id_o <= 2'h1; // RL13
            end else if (irq_d[2]) begin
                irq_id_o <= 2'h2; // RL13
            end else begin
                irq_id_o <= 2'h3; // RL13
            end
        end
    end

    // Read multiplexer; counters read as held before any decrement.
    always_comb begin
        rd_val = '0;
        if (addr_i == `TRT_OFF_START) begin
            rd_val[NCH-1:0] = run_q;
        end else if (addr_i == `TRT_OFF_PINCTL) begin
            rd_val[`TRT_OE_BIT] = oe_q;
        end else if (addr_i == `TRT_OFF_CAPTURE) begin
            rd_val = capr_q;
        end
        for (int c = 0; c < NCH; c++) begin
            if (addr_i == ch_addr(c, `TRT_OFF_RELOAD)) begin
                rd_val = rel_q[c];
            end else if (addr_i == ch_addr(c, `TRT_OFF_COUNT)) begin
                rd_val = cnt_q[c]; // RL16
            end else if (addr_i == ch_addr(c, `TRT_OFF_CTRL)) begin
                rd_val[`TRT_CKS_MSB:`TRT_CKS_LSB]   = cks_q[c];
                rd_val[`TRT_EDGE_MSB:`TRT_EDGE_LSB] = edge_q[c];
                rd_val[`TRT_UNDERFLOW_IRQ_ENABLE_BIT]               = underflow_irq_enable_q[c];
                rd_val[`TRT_UF_BIT]                 = uf_q[c];
                if (c == CAP) begin
                    rd_val[`TRT_CAPC_MSB:`TRT_CAPC_LSB] = capc_q;
                    rd_val[`TRT_CAPF_BIT]               = capf_q;
                end
            end
        end
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= rd_val; // RL16
        end else begin
            rdata_o <= '0;
        end
    end

    // The pin carries the RTC output whenever the output enable is set.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            timer_clock_pin_o    <= 1'b0;
            timer_clock_pin_oe_o <= 1'b0;
        end else begin
            timer_clock_pin_o    <= rtc_q;
            timer_clock_pin_oe_o <= oe_q;
        end
    end

endmodule

// ---- core/trt_regs.svh ----
// Register map, field positions, codes and reset values of the reload timer.
`ifndef TRT_REGS_SVH
`define TRT_REGS_SVH

`define TRT_ADDR_W        8
`define TRT_DATA_W        32
`define TRT_NUM_CH        3
`define TRT_CAP_CH        2

`define TRT_OFF_PINCTL    8'h00
`define TRT_OFF_START     8'h04
`define TRT_CH_BASE       8'h08
`define TRT_CH_STRIDE     8'h0c
`define TRT_OFF_RELOAD    8'h00
`define TRT_OFF_COUNT     8'h04
`define TRT_OFF_CTRL      8'h08
`define TRT_OFF_CAPTURE   8'h2c

`define TRT_CKS_LSB       0
`define TRT_CKS_MSB       2
`define TRT_EDGE_LSB      3
`define TRT_EDGE_MSB      4
`define TRT_UNDERFLOW_IRQ_ENABLE_BIT      5
`define TRT_CAPC_LSB      6
`define TRT_CAPC_MSB      7
`define TRT_UF_BIT        8
`define TRT_CAPF_BIT      9
`define TRT_OE_BIT        0

`define TRT_CKS_DIV4      3'h0
`define TRT_CKS_DIV16     3'h1
`define TRT_CKS_DIV64     3'h2
`define TRT_CKS_DIV256    3'h3
`define TRT_CKS_DIV1024   3'h4
`define TRT_CKS_RTC       3'h6
`define TRT_CKS_PIN       3'h7

`define TRT_EDGE_RISE     2'h0
`define TRT_EDGE_FALL     2'h1

`define TRT_CAPC_OFF      2'h0
`define TRT_CAPC_DMA      2'h2
`define TRT_CAPC_IRQ      2'h3

`define TRT_PRE_W         10
`define TRT_NUM_PRE       5

`define TRT_RST_WORD      32'h0000_0000
`define TRT_RST_CKS       3'h0
`define TRT_RST_EDGE      2'h0
`define TRT_RST_CAPC      2'h0

`endif

// ---- core/trt_pkg.sv ----
// Shared types of the reload timer.
package trt_pkg;
`include "trt_regs.svh"

    typedef logic [`TRT_ADDR_W-1:0] trt_addr_t;
    typedef logic [`TRT_DATA_W-1:0] trt_word_t;
    typedef logic [2:0]             trt_cks_t;
    typedef logic [1:0]             trt_edge_t;

endpackage

// ---- core/trt_prescaler.sv ----
// Free-running prescaler giving one-cycle enables at clk/4 up to clk/1024.
`timescale 1ns/1ps
module trt_prescaler
    import trt_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    // Rate enables, bit k pulses once every 4^(k+1) cycles
    output logic [`TRT_NUM_PRE-1:0]      tick_o
);

    logic [`TRT_PRE_W-1:0] cnt_q;

    // Mask of the low 2k+2 bits that must all be one for rate k.
    function automatic logic [`TRT_PRE_W-1:0] rate_mask(input int k);
        logic [`TRT_PRE_W-1:0] m;
        m = '0;
        for (int b = 0; b < `TRT_PRE_W; b++) begin
            if (b < 2 * k + 2) begin
                m[b] = 1'b1;
            end
        end
        return m;
    endfunction

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + `TRT_PRE_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tick_o <= '0;
        end else begin
            for (int k = 0; k < `TRT_NUM_PRE; k++) begin
                tick_o[k] <= ((cnt_q & rate_mask(k)) == rate_mask(k)); // RL6
            end
        end
    end

endmodule

// ---- sim/trt_timer_assertions.sv ----
// Port-level assertions for the reload timer and their bind.
`timescale 1ns/1ps
`include "trt_regs.svh"
module trt_chk (
    // Clock and reset
    input wire logic                   clk_i,
    input wire logic                   sys_rst_i,
    // Register port
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [`TRT_DATA_W-1:0] rdata_o,
    // Power state and pin
    input wire logic                   standby_i,
    input wire logic                   timer_clock_pin_oe_o,
    // Interrupts and DMA
    input wire logic [3:0]             irq_o,
    input wire logic                   irq_any_o,
    input wire logic [1:0]             irq_id_o,
    input wire logic                   dma_req_o,
    input wire logic                   dma_ack_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_dma_hold:
        assert property (dma_req_o && !dma_ack_i |=> dma_req_o)
        else $error("DMA request dropped without acknowledge");
    a_dma_ack_clear:
        assert property (dma_req_o && dma_ack_i |=> !dma_req_o)
        else $error("DMA request not cleared by acknowledge");
    a_standby_no_capture:
        assert property (standby_i && !dma_req_o |=> !dma_req_o)
        else $error("Capture request raised in standby");
    a_irq_any_or:
        assert property ($stable(irq_o) |-> irq_any_o == (|irq_o))
        else $error("Combined interrupt differs from OR of sources");
    a_irq_id_rank:
        assert property (!$past(sys_rst_i) && $stable(irq_o) |->
            irq_id_o == (irq_o[0] ? 2'h0 : irq_o[1] ? 2'h1 :
                         irq_o[2] ? 2'h2 : 2'h3))
        else $error("Interrupt index does not follow priority");
    a_irq_fall_write:
        assert property (!$past(sys_rst_i) && |($past(irq_o) & ~irq_o)
            |-> $past(wr_i, 2))
        else $error("Interrupt dropped without a register write");
    a_oe_by_write:
        assert property (!$past(sys_rst_i) && $changed(timer_clock_pin_oe_o)
            |-> $past(wr_i) || $past(wr_i, 2))
        else $error("Pin direction changed without a register write");
    a_rdata_idle:
        assert property (!$past(rd_i) |-> rdata_o == '0)
        else $error("Read data present without a read");

    c_dma: cover property ($rose(dma_req_o));
    c_capture_irq: cover property ($rose(irq_o[3]));
    c_two_irqs: cover property (irq_o[1] && irq_o[3]);
endmodule

bind trt_timer trt_chk trt_chk_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .standby_i(standby_i), .timer_clock_pin_oe_o(timer_clock_pin_oe_o),
    .irq_o(irq_o), .irq_any_o(irq_any_o), .irq_id_o(irq_id_o),
    .dma_req_o(dma_req_o), .dma_ack_i(dma_ack_i)
);

// ---- sim/trt_dma_model.sv ----
// DMA controller stand-in that serves capture requests after a latency.
`timescale 1ns/1ps
module trt_dma_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Request handshake and service latency
    input  wire logic       dma_req_i,
    input  wire logic [4:0] lat_i,
    output logic            dma_ack_o,
    // Transfers finished so far
    output logic [7:0]      done_o
);
    logic [4:0] wait_q;
    logic       ack_q;
    logic [7:0] done_q;

    assign dma_ack_o = ack_q;
    assign done_o    = done_q;

    // The acknowledge lasts one cycle only, as a real controller's does.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || ack_q || !dma_req_i) begin
            ack_q  <= 1'b0;
            wait_q <= 5'h00;
        end else if (wait_q >= lat_i) begin
            ack_q  <= 1'b1;
        end else begin
            wait_q <= wait_q + 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_q <= 8'h00;
        end else if (ack_q && dma_req_i) begin
            done_q <= done_q + 8'h01;
        end
    end
endmodule

// ---- sim/testbench.sv ----
// Self-checking testbench for the reload timer.
`timescale 1ns/1ps
`include "trt_regs.svh"
module testbench import trt_pkg::*;;
    localparam int st  = `TRT_OFF_START;
    localparam int cap = `TRT_OFF_CAPTURE;
    localparam int pin = `TRT_OFF_PINCTL;
    logic       clk   = 1'b0;
    logic       rst   = 1'b1;
    trt_addr_t  addr  = '0;
    trt_word_t  wdata = '0;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    trt_word_t  rdata;
    logic       rtc   = 1'b0;
    logic       stby  = 1'b0;
    logic       timer_clock_pin  = 1'b0;
    logic       oe;
    logic       tout;
    logic [3:0] irq;
    logic       irq_any;
    logic [1:0] irq_id;
    logic       dreq;
    logic       dack;
    logic [4:0] lat   = 5'd0;
    logic [7:0] done;
    int         miscompares = 0;
    int         cmp_count   = 0;
    int tbl [13][4] = '{'{0,0,0,2}, '{1,0,0,2}, '{2,0,0,2}, '{3,0,0,2},
        '{4,0,0,2}, '{5,0,0,0}, '{6,0,0,3}, '{7,0,0,3}, '{7,1,0,3},
        '{7,2,0,6}, '{7,3,0,6}, '{0,0,1,0}, '{6,0,1,3}};

    trt_timer trt_timer_i (
        .clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rtc_clk_i(rtc),
        .standby_i(stby), .timer_clock_pin_i(timer_clock_pin), .timer_clock_pin_o(tout), .timer_clock_pin_oe_o(oe),
        .irq_o(irq), .irq_any_o(irq_any), .irq_id_o(irq_id),
        .dma_req_o(dreq), .dma_ack_i(dack)
    );
    trt_dma_model trt_dma_model_i (
        .clk_i(clk), .sys_rst_i(rst), .dma_req_i(dreq), .lat_i(lat),
        .dma_ack_o(dack), .done_o(done)
    );

    always #2 clk = ~clk;

    function automatic int ra(input int ch, input int off);
        return `TRT_CH_BASE + `TRT_CH_STRIDE * ch + off;
    endfunction
    function automatic trt_word_t ctl(input int s, e, u, c, f);
        return {22'h0, f[1:0], c[1:0], u[0], e[1:0], s[2:0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input trt_word_t got, input trt_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bw(input int a, input trt_word_t d);
        @(posedge clk);
        addr  <= trt_addr_t'(a);
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rchk(input int a, input trt_word_t exp);
        @(posedge clk);
        addr <= trt_addr_t'(a);
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        chk(rdata, exp);
    endtask
    task automatic pulse(input bit use_rtc);
        @(posedge clk);
        if (use_rtc)
            rtc <= 1'b1;
        else
            timer_clock_pin <= 1'b1;
        cyc(4);
        rtc  <= 1'b0;
        timer_clock_pin <= 1'b0;
        cyc(4);
    endtask
    task automatic wait_irq(input int i);
        for (int k = 0; k < 200 && irq[i] !== 1'b1; k++)
            @(posedge clk);
    endtask

    task automatic t_reset();
        int regs [6] = '{ra(0, 8), ra(1, 8), ra(2, 8), cap, st, 8'hfc};
        foreach (regs[i])
            rchk(regs[i], 32'h0);
        bw(8'hfc, 32'hffff_ffff);
        rchk(8'hfc, 32'h0);
        bw(ra(0, 0), 32'hffff_ffff);
        rchk(ra(0, 0), 32'hffff_ffff);
        bw(pin, 32'h1);
        cyc(2);
        chk(oe, 1'b1);
        rtc <= 1'b1;
        cyc(3);
        chk(tout, 1'b1);
        rtc <= 1'b0;
        bw(pin, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_underflow();
        trt_word_t held;
        bw(ra(0, 8), ctl(0, 0, 1, 0, 1));
        bw(ra(0, 0), 32'h3);
        bw(ra(0, 4), 32'h1);
        bw(st, 32'h1);
        wait_irq(0);
        chk(irq, 4'h1);
        chk(irq_id, 2'h0);
        bw(st, 32'h0);
        @(posedge clk);
        addr <= trt_addr_t'(ra(0, 4));
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        held = rdata;
        chk(held <= 32'h3, 1'b1);
        cyc(20);
        rchk(ra(0, 4), held);
        rchk(ra(0, 8), ctl(0, 0, 1, 0, 1));
        bw(ra(0, 8), ctl(0, 0, 1, 0, 1));
        rchk(ra(0, 8), ctl(0, 0, 1, 0, 1));
        bw(ra(0, 8), ctl(0, 0, 0, 0, 0));
        rchk(ra(0, 8), 32'h0);
        chk(irq, 4'h0);
        bw(ra(0, 4), 32'h0);
        bw(st, 32'h1);
        cyc(12);
        bw(st, 32'h0);
        rchk(ra(0, 8), ctl(0, 0, 0, 0, 1));
        chk(irq, 4'h0);
        bw(ra(0, 8), ctl(0, 0, 1, 0, 1));
        cyc(2);
        chk(irq, 4'h1);
        bw(ra(0, 8), ctl(0, 0, 0, 0, 0));
        $display("t_underflow done");
    endtask

    task automatic t_rates();
        for (int i = 0; i < 13; i++) begin
            stby <= tbl[i][2][0];
            rtc  <= 1'b0;
            bw(ra(1, 8), ctl(tbl[i][0], tbl[i][1], 0, 0, 1));
            bw(ra(1, 4), 32'd100);
            bw(st, 32'h2);
            if (tbl[i][0] < 5)
                cyc((8 << (2 * tbl[i][0])) - 2);
            else if (tbl[i][0] == 5)
                cyc(6);
            else begin
                repeat (3) pulse(tbl[i][0] == 6);
                cyc(4);
            end
            bw(st, 32'h0);
            stby <= 1'b0;
            rchk(ra(1, 4), 32'd100 - tbl[i][3]);
        end
        $display("t_rates done");
    endtask

    task automatic t_capture();
        int d0;
        d0 = done;
        bw(pin, 32'h0);
        bw(ra(2, 8), ctl(4, 0, 0, 3, 1));
        bw(ra(2, 4), 32'h55);
        pulse(0);
        rchk(cap, 32'h55);
        chk(irq[3], 1'b1);
        chk(done, d0 + 1);
        bw(ra(2, 4), 32'h66);
        pulse(0);
        rchk(cap, 32'h55);
        chk(done, d0 + 2);
        bw(ra(2, 8), ctl(4, 1, 0, 3, 1));
        cyc(2);
        chk(irq[3], 1'b0);
        pulse(0);
        rchk(cap, 32'h66);
        bw(ra(2, 8), ctl(4, 1, 0, 2, 1));
        bw(ra(2, 4), 32'h77);
        pulse(0);
        rchk(cap, 32'h77);
        chk(irq[3], 1'b0);
        rchk(ra(2, 8), ctl(4, 1, 0, 2, 2));
        bw(ra(2, 8), ctl(4, 1, 0, 0, 1));
        bw(ra(2, 4), 32'h88);
        d0 = done;
        pulse(0);
        rchk(cap, 32'h77);
        chk(done, d0);
        bw(ra(2, 8), ctl(4, 1, 0, 3, 1));
        stby <= 1'b1;
        pulse(0);
        stby <= 1'b0;
        rchk(cap, 32'h77);
        chk(done, d0);
        lat <= 5'd20;
        pulse(0);
        pulse(0);
        cyc(40);
        chk(done, d0 + 1);
        rchk(cap, 32'h88);
        lat <= 5'd0;
        $display("t_capture done");
    endtask

    task automatic t_priority();
        bw(ra(1, 8), ctl(0, 0, 1, 0, 1));
        bw(ra(1, 4), 32'h0);
        bw(st, 32'h2);
        wait_irq(1);
        bw(st, 32'h0);
        chk(irq, 4'ha);
        chk(irq_any, 1'b1);
        chk(irq_id, 2'h1);
        bw(ra(1, 8), ctl(0, 0, 1, 0, 0));
        cyc(3);
        chk(irq_id, 2'h3);
        $display("t_priority done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_underflow();
        t_rates();
        t_capture();
        t_priority();
        report_and_stop();
    end
endmodule
